// File: hw/agu_defs.svh
// Constants of the address generation unit
// Functional notes
// - Ten data registers, eight pointers, eight offsets paired by index.
// - Displacement mode: pointer plus signed extension displacement, four extra clocks.
// - Displacement mode fetches one extension word; any memory space allowed.
// - PC-relative branch: 15-bit signed in-word offset, no extension, four clocks.
// - PC-relative branch targets program memory at PC plus offset.
// - Load relative address writes PC plus immediate or pointer value.
// - Load relative address costs four clocks static, two dynamic.
// - Load relative address uses one extension word static, none dynamic.
// - Modifier upper byte all ones selects multiple wraparound; low bits mask.
// - Wraparound keeps pointer inside block sharing its upper bits.
// - Wraparound accepts any offset value, even beyond buffer size.
// - Pointer updates: post inc/dec by one or offset, pre-decrement by one.
`ifndef AGU_DEFS_SVH
`define AGU_DEFS_SVH
`define AGU_WORD_W 32
`define AGU_NUM_DATA 10
`define AGU_NUM_PTR 8
`define AGU_BRANCH_OFS_W 15
`define AGU_MOD_SEL_MSB 31
`define AGU_MOD_SEL_LSB 24
`define AGU_MOD_SEL_VAL 8'hFF
`define AGU_MASK_W 24
`define AGU_CLK_DISP 4
`define AGU_CLK_BRANCH 4
`define AGU_CLK_LRA_STAT 4
`define AGU_CLK_LRA_DYN 2
`define AGU_EXT_DISP 1
`define AGU_EXT_BRANCH 0
`define AGU_EXT_LRA_STAT 1
`define AGU_EXT_LRA_DYN 0
`define AGU_RESET_WORD 32'h0000_0000
`define AGU_LINEAR_MOD 32'hFFFF_FFFF
`endif

// File: hw/agu_pkg.sv
// Types of the address generation unit
package agu_pkg;
    typedef enum logic [3:0] {
        AGU_OP_NONE = 4'h0,
        AGU_OP_DISP = 4'h1,
        AGU_OP_BRANCH = 4'h2,
        AGU_OP_LRA_STAT = 4'h3,
        AGU_OP_LRA_DYN = 4'h4,
        AGU_OP_UPD = 4'h5,
        AGU_OP_WR_PTR = 4'h6,
        AGU_OP_WR_OFS = 4'h7,
        AGU_OP_WR_MOD = 4'h8,
        AGU_OP_WR_DATA = 4'h9
    } agu_op_t;
    typedef enum logic [2:0] {
        AGU_UPD_NONE = 3'h0,
        AGU_UPD_POST_INC1 = 3'h1,
        AGU_UPD_POST_DEC1 = 3'h2,
        AGU_UPD_POST_INCN = 3'h3,
        AGU_UPD_POST_DECN = 3'h4,
        AGU_UPD_PRE_DEC1 = 3'h5
    } agu_upd_t;
    typedef enum logic [1:0] {
        AGU_SPACE_P = 2'h0,
        AGU_SPACE_X = 2'h1,
        AGU_SPACE_Y = 2'h2,
        AGU_SPACE_L = 2'h3
    } agu_space_t;
    typedef enum logic [1:0] {
        AGU_ST_IDLE = 2'b01,
        AGU_ST_BUSY = 2'b10
    } agu_state_t;
    typedef struct packed {
        agu_op_t op;
        agu_upd_t upd;
        agu_space_t space;
        logic [2:0] ptr_idx;
        logic [3:0] dst_idx;
        logic dst_is_ptr;
        logic [31:0] word;
        logic [31:0] ext;
        logic [31:0] pc;
    } agu_req_t;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        agu_space_t space;
        logic branch;
        logic [2:0] extra_clk;
        logic [1:0] ext_words;
    } agu_rsp_t;
endpackage : agu_pkg

// File: hw/agu_modulo_upd.sv
// Pointer update arithmetic, linear or multiple wraparound
`timescale 1ns/100ps
`include "agu_defs.svh"
module agu_modulo_upd
    import agu_pkg::*;
(
    // Operands
    input wire logic [31:0] ptr_i,
    input wire logic [31:0] ofs_i,
    input wire logic [31:0] mod_i,
    input wire agu_upd_t upd_i,
    // Results
    output logic [31:0] addr_o,
    output logic [31:0] ptr_o
);
    logic wrap;
    logic [31:0] mask;
    logic [31:0] step;
    logic [31:0] sum;
    logic [31:0] pre;
    // -----------------------------------------------
    // Mode select
    // -----------------------------------------------
    assign wrap = (mod_i[`AGU_MOD_SEL_MSB:`AGU_MOD_SEL_LSB] == `AGU_MOD_SEL_VAL);
    assign mask = {8'h00, mod_i[`AGU_MASK_W-1:0]};
    always_comb begin
        step = 32'h0000_0000;
        unique case (upd_i)
            AGU_UPD_POST_INC1: step = 32'h0000_0001;
            AGU_UPD_POST_DEC1: step = 32'hFFFF_FFFF;
            AGU_UPD_POST_INCN: step = ofs_i;
            AGU_UPD_POST_DECN: step = 32'h0000_0000 - ofs_i;
            AGU_UPD_PRE_DEC1: step = 32'hFFFF_FFFF;
            default: step = 32'h0000_0000;
        endcase
    end
    assign sum = ptr_i + step;
    // Upper bits fixed, low M bits from the sum
    assign pre = wrap ? ((ptr_i & ~mask) | (sum & mask)) : sum;
    assign ptr_o = pre;
    assign addr_o = (upd_i == AGU_UPD_PRE_DEC1) ? pre : ptr_i;
endmodule : agu_modulo_upd

// File: hw/agu_top.sv
// Address generation unit top
`timescale 1ns/100ps
`include "agu_defs.svh"
module agu_top
    import agu_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Request from program controller
    input wire logic req_valid_i,
    input wire agu_req_t req_i,
    // Answer
    output logic ready_o,
    output agu_rsp_t rsp_o,
    output logic dst_we_o,
    output logic [31:0] dst_data_o,
    output logic [3:0] dst_idx_o,
    output logic dst_is_ptr_o
);
    // -----------------------------------------------
    // Register files
    // -----------------------------------------------
    logic [31:0] data_reg_r [`AGU_NUM_DATA];
    logic [31:0] address_pointer_reg_r [`AGU_NUM_PTR];
    logic [31:0] pointer_offset_reg_r [`AGU_NUM_PTR];
    logic [31:0] modifier_reg_r [`AGU_NUM_PTR];
    agu_state_t state_r;
    logic [2:0] cnt_r;
    logic [31:0] ptr_sel;
    logic [31:0] ofs_sel;
    logic [31:0] mod_sel;
    logic [31:0] upd_addr;
    logic [31:0] upd_ptr;
    logic [31:0] branch_ofs;
    logic take;
    agu_rsp_t rsp_nxt;
    logic [2:0] cnt_nxt;

    assign take = req_valid_i && (state_r == AGU_ST_IDLE);
    assign ptr_sel = address_pointer_reg_r[req_i.ptr_idx];
    assign ofs_sel = pointer_offset_reg_r[req_i.ptr_idx];
    assign mod_sel = modifier_reg_r[req_i.ptr_idx];
    assign branch_ofs = {{17{req_i.word[`AGU_BRANCH_OFS_W-1]}},
                         req_i.word[`AGU_BRANCH_OFS_W-1:0]};

    agu_modulo_upd u_upd (
        .ptr_i(ptr_sel),
        .ofs_i(ofs_sel),
        .mod_i(mod_sel),
        .upd_i(req_i.upd),
        .addr_o(upd_addr),
        .ptr_o(upd_ptr)
    );

    // -----------------------------------------------
    // Address formation
    // -----------------------------------------------
    always_comb begin
        rsp_nxt = '0;
        cnt_nxt = 3'd0;
        if (take) begin
            rsp_nxt.space = req_i.space;
            unique case (req_i.op)
                AGU_OP_DISP: begin
                    rsp_nxt.valid = 1'b1;
                    rsp_nxt.addr = ptr_sel + req_i.ext;
                    rsp_nxt.extra_clk = 3'(`AGU_CLK_DISP);
                    rsp_nxt.ext_words = 2'(`AGU_EXT_DISP);
                    cnt_nxt = 3'(`AGU_CLK_DISP);
                end
                AGU_OP_BRANCH: begin
                    rsp_nxt.valid = 1'b1;
                    rsp_nxt.branch = 1'b1;
                    rsp_nxt.space = AGU_SPACE_P;
                    rsp_nxt.addr = req_i.pc + branch_ofs;
                    rsp_nxt.extra_clk = 3'(`AGU_CLK_BRANCH);
                    rsp_nxt.ext_words = 2'(`AGU_EXT_BRANCH);
                    cnt_nxt = 3'(`AGU_CLK_BRANCH);
                end
                AGU_OP_LRA_STAT: begin
                    rsp_nxt.valid = 1'b1;
                    rsp_nxt.addr = req_i.pc + req_i.ext;
                    rsp_nxt.extra_clk = 3'(`AGU_CLK_LRA_STAT);
                    rsp_nxt.ext_words = 2'(`AGU_EXT_LRA_STAT);
                    cnt_nxt = 3'(`AGU_CLK_LRA_STAT);
                end
                AGU_OP_LRA_DYN: begin
                    rsp_nxt.valid = 1'b1;
                    rsp_nxt.addr = req_i.pc + ptr_sel;
                    rsp_nxt.extra_clk = 3'(`AGU_CLK_LRA_DYN);
                    rsp_nxt.ext_words = 2'(`AGU_EXT_LRA_DYN);
                    cnt_nxt = 3'(`AGU_CLK_LRA_DYN);
                end
                AGU_OP_UPD: begin
                    rsp_nxt.valid = 1'b1;
                    rsp_nxt.addr = upd_addr;
                end
                default: rsp_nxt = '0;
            endcase
        end
    end

    // -----------------------------------------------
    // Extra clock sequencing
    // -----------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r <= AGU_ST_IDLE;
            cnt_r <= 3'd0;
            ready_o <= 1'b1;
        end else begin
            unique case (state_r)
                AGU_ST_IDLE: begin
                    if (cnt_nxt > 3'd1) begin
                        state_r <= AGU_ST_BUSY;
                        cnt_r <= cnt_nxt - 3'd1;
                        ready_o <= 1'b0;
                    end
                end
                AGU_ST_BUSY: begin
                    cnt_r <= cnt_r - 3'd1;
                    if (cnt_r == 3'd1) begin
                        state_r <= AGU_ST_IDLE;
                        ready_o <= 1'b1;
                    end
                end
                default: begin
                    state_r <= AGU_ST_IDLE;
                    ready_o <= 1'b1;
                end
            endcase
        end
    end

    // -----------------------------------------------
    // Answer and destination write
    // -----------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rsp_o <= '0;
            dst_we_o <= 1'b0;
            dst_data_o <= `AGU_RESET_WORD;
            dst_idx_o <= 4'd0;
            dst_is_ptr_o <= 1'b0;
        end else begin
            rsp_o <= rsp_nxt;
            dst_we_o <= take && (req_i.op == AGU_OP_LRA_STAT || req_i.op == AGU_OP_LRA_DYN);
            dst_data_o <= rsp_nxt.addr;
            dst_idx_o <= req_i.dst_idx;
            dst_is_ptr_o <= req_i.dst_is_ptr;
        end
    end

    // -----------------------------------------------
    // Register file writes
    // -----------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < `AGU_NUM_PTR; i++) begin
                address_pointer_reg_r[i] <= `AGU_RESET_WORD;
                pointer_offset_reg_r[i] <= `AGU_RESET_WORD;
                modifier_reg_r[i] <= `AGU_LINEAR_MOD;
            end
        end else if (take) begin
            unique case (req_i.op)
                AGU_OP_UPD: address_pointer_reg_r[req_i.ptr_idx] <= upd_ptr;
                AGU_OP_WR_PTR: address_pointer_reg_r[req_i.ptr_idx] <= req_i.word;
                AGU_OP_WR_OFS: pointer_offset_reg_r[req_i.ptr_idx] <= req_i.word;
                AGU_OP_WR_MOD: modifier_reg_r[req_i.ptr_idx] <= req_i.word;
                AGU_OP_LRA_STAT, AGU_OP_LRA_DYN: begin
                    if (req_i.dst_is_ptr) begin
                        address_pointer_reg_r[req_i.dst_idx[2:0]] <= rsp_nxt.addr;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < `AGU_NUM_DATA; i++) begin
                data_reg_r[i] <= `AGU_RESET_WORD;
            end
        end else if (take && req_i.dst_idx < 4'(`AGU_NUM_DATA)) begin
            if (req_i.op == AGU_OP_WR_DATA) begin
                data_reg_r[req_i.dst_idx] <= req_i.word;
            end else if ((req_i.op == AGU_OP_LRA_STAT || req_i.op == AGU_OP_LRA_DYN)
                         && !req_i.dst_is_ptr) begin
                data_reg_r[req_i.dst_idx] <= rsp_nxt.addr;
            end
        end
    end
endmodule : agu_top

// File: dv/agu_chk.sv
// Assertion checker of the address generation unit
`timescale 1ns/100ps
module agu_chk
    import agu_pkg::*;
(
    // Clock and request
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_valid_i,
    input wire agu_req_t req_i,
    // Answer
    input wire logic ready_o,
    input wire agu_rsp_t rsp_o,
    input wire logic dst_we_o,
    input wire logic [31:0] dst_data_o,
    input wire logic [3:0] dst_idx_o,
    input wire logic dst_is_ptr_o
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    wire logic tk = req_valid_i && ready_o;
    wire agu_op_t op = req_i.op;
    a_disp_cost: assert property (tk && op == AGU_OP_DISP |=>
        rsp_o.valid && rsp_o.extra_clk == 3'h4 && rsp_o.ext_words == 2'h1
        && rsp_o.space == $past(req_i.space)) else $error("displacement answer wrong");
    a_disp_stall: assert property (tk && op == AGU_OP_DISP |=>
        !ready_o [*3] ##1 ready_o) else $error("displacement stall length wrong");
    a_branch_target: assert property (tk && op == AGU_OP_BRANCH |=>
        rsp_o.valid && rsp_o.branch && rsp_o.space == AGU_SPACE_P && rsp_o.addr ==
        $past(req_i.pc) + {{17{$past(req_i.word[14])}}, $past(req_i.word[14:0])})
        else $error("branch target wrong");
    a_branch_cost: assert property (tk && op == AGU_OP_BRANCH |=>
        rsp_o.extra_clk == 3'h4 && rsp_o.ext_words == 2'h0 && !ready_o ##1 !ready_o [*2]
        ##1 ready_o) else $error("branch cost wrong");
    a_lra_static: assert property (tk && op == AGU_OP_LRA_STAT |=>
        dst_we_o && dst_data_o == $past(req_i.pc) + $past(req_i.ext) && !ready_o
        && rsp_o.extra_clk == 3'h4 && rsp_o.ext_words == 2'h1 ##1 !ready_o [*2] ##1 ready_o)
        else $error("static relative load wrong");
    a_lra_dynamic: assert property (tk && op == AGU_OP_LRA_DYN |=>
        dst_we_o && !ready_o && dst_idx_o == $past(req_i.dst_idx) && rsp_o.extra_clk == 3'h2
        && rsp_o.ext_words == 2'h0 ##1 ready_o) else $error("dynamic relative load wrong");
    a_upd_flow: assert property (tk && op == AGU_OP_UPD |=>
        rsp_o.valid && ready_o && !dst_we_o) else $error("pointer update answer wrong");
    a_write_quiet: assert property (tk && op inside {AGU_OP_WR_PTR,
        AGU_OP_WR_OFS, AGU_OP_WR_MOD, AGU_OP_WR_DATA} |=> ready_o && !rsp_o.valid
        && !dst_we_o) else $error("register write answered");
    c_lra_dyn: cover property (tk && op == AGU_OP_LRA_DYN);
    c_branch: cover property (tk && op == AGU_OP_BRANCH);
    c_upd_pair: cover property (tk && op == AGU_OP_UPD ##1 tk && op == AGU_OP_UPD);
endmodule : agu_chk
bind agu_top agu_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .ready_o(ready_o), .rsp_o(rsp_o), .dst_we_o(dst_we_o),
    .dst_data_o(dst_data_o), .dst_idx_o(dst_idx_o), .dst_is_ptr_o(dst_is_ptr_o));

// File: dv/agu_pc_model.sv
// Program controller model issuing requests to the address unit
`timescale 1ns/100ps
module agu_pc_model
    import agu_pkg::*;
(
    // Clock and handshake
    input wire logic clk_i,
    input wire logic ready_i,
    // Request
    output logic req_valid_o,
    output agu_req_t req_o
);
    // --------
    // Requests
    // --------
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    task automatic issue(input agu_req_t r);
        req_valid_o <= 1'b1;
        req_o <= r;
        do @(posedge clk_i); while (ready_i !== 1'b1);
    endtask : issue
    // Released request lines show no stale value
    task automatic idle();
        req_valid_o <= 1'b0;
        req_o <= ~req_o;
    endtask : idle
endmodule : agu_pc_model

// File: dv/tb_address_generation_unit.sv
// Testbench of the address generation unit
`timescale 1ns/100ps
module tb_address_generation_unit import agu_pkg::*;;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic vld, rdy, we, dp;
    agu_req_t req;
    agu_rsp_t rsp;
    logic [31:0] dd;
    logic [3:0] di;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    always #5 clk_i = ~clk_i;
    agu_pc_model pcm (.clk_i(clk_i), .ready_i(rdy), .req_valid_o(vld), .req_o(req));
    agu_top dut (.clk_i(clk_i), .srst_i(srst_i), .req_valid_i(vld), .req_i(req), .ready_o(rdy),
        .rsp_o(rsp), .dst_we_o(we), .dst_data_o(dd), .dst_idx_o(di), .dst_is_ptr_o(dp));
    // -----
    // Tasks
    // -----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    function automatic agu_req_t mk(agu_op_t o, agu_upd_t u, agu_space_t s, logic [2:0] p,
        logic [3:0] d, logic dip, logic [31:0] w, logic [31:0] e, logic [31:0] pc);
        return '{o, u, s, p, d, dip, w, e, pc};
    endfunction : mk
    task automatic go(input agu_req_t r);
        pcm.issue(r);
        pcm.idle();
        @(posedge clk_i);
    endtask : go
    task automatic t_disp();
        go(mk(AGU_OP_WR_PTR, AGU_UPD_NONE, AGU_SPACE_P, 3'h6, '0, 1'b0, 32'h0000_6000, '0, '0));
        go(mk(AGU_OP_WR_OFS, AGU_UPD_NONE, AGU_SPACE_P, 3'h6, '0, 1'b0, 32'h0000_0010, '0, '0));
        go(mk(AGU_OP_WR_OFS, AGU_UPD_NONE, AGU_SPACE_P, 3'h7, '0, 1'b0, 32'h0000_0999, '0, '0));
        for (int s = 0; s < 4; s++) begin
            go(mk(AGU_OP_DISP, AGU_UPD_NONE, agu_space_t'(2'(s)), 3'h6, '0, 1'b0, '0,
                32'h0000_0004, '0));
            chk(rsp.addr, 32'h0000_6004);
            chk({rsp.space, rsp.extra_clk, rsp.ext_words}, {25'h0, 2'(s), 5'h11});
        end
        go(mk(AGU_OP_UPD, AGU_UPD_POST_INCN, AGU_SPACE_X, 3'h6, '0, 1'b0, '0, '0, '0));
        chk(rsp.addr, 32'h0000_6000);
        go(mk(AGU_OP_UPD, AGU_UPD_NONE, AGU_SPACE_X, 3'h6, '0, 1'b0, '0, '0, '0));
        chk(rsp.addr, 32'h0000_6010);
    endtask : t_disp
    task automatic t_branch();
        go(mk(AGU_OP_BRANCH, AGU_UPD_NONE, AGU_SPACE_X, '0, '0, 1'b0, 32'h0000_7FFC, '0,
            32'h0410_7000));
        chk(rsp.addr, 32'h0410_6FFC);
        chk({rsp.branch, rsp.space, rsp.extra_clk, rsp.ext_words}, 32'h0000_0090);
        go(mk(AGU_OP_BRANCH, AGU_UPD_NONE, AGU_SPACE_Y, '0, '0, 1'b0, 32'hFFFF_8004, '0,
            32'h0410_7000));
        chk(rsp.addr, 32'h0410_7004);
    endtask : t_branch
    task automatic t_lra();
        go(mk(AGU_OP_LRA_STAT, AGU_UPD_NONE, AGU_SPACE_P, '0, 4'h9, 1'b0, '0, 32'h0000_0150,
            32'h0000_0102));
        chk(dd, 32'h0000_0252);
        chk({we, dp, di, rsp.extra_clk, rsp.ext_words}, 32'h0000_0531);
        go(mk(AGU_OP_WR_PTR, AGU_UPD_NONE, AGU_SPACE_P, 3'h1, '0, 1'b0, 32'h0000_0150, '0, '0));
        go(mk(AGU_OP_LRA_DYN, AGU_UPD_NONE, AGU_SPACE_P, 3'h1, 4'h4, 1'b1, '0, '0, 32'h0000_0101));
        chk(dd, 32'h0000_0251);
        chk({we, dp, di, rsp.extra_clk, rsp.ext_words}, 32'h0000_0688);
        go(mk(AGU_OP_UPD, AGU_UPD_NONE, AGU_SPACE_X, 3'h4, '0, 1'b0, '0, '0, '0));
        chk(rsp.addr, 32'h0000_0251);
    endtask : t_lra
    task automatic t_wrap();
        agu_upd_t u[6] = '{AGU_UPD_POST_INCN, AGU_UPD_POST_DECN, AGU_UPD_PRE_DEC1,
            AGU_UPD_POST_DEC1, AGU_UPD_POST_INC1, AGU_UPD_NONE};
        logic [31:0] a[6] = '{32'h0000_0141, 32'h0000_0172, 32'h0000_0140, 32'h0000_0140,
            32'h0000_017F, 32'h0000_0140};
        go(mk(AGU_OP_WR_PTR, AGU_UPD_NONE, AGU_SPACE_P, '0, '0, 1'b0, 32'h0000_0141, '0, '0));
        go(mk(AGU_OP_WR_OFS, AGU_UPD_NONE, AGU_SPACE_P, '0, '0, 1'b0, 32'h0000_0271, '0, '0));
        go(mk(AGU_OP_WR_MOD, AGU_UPD_NONE, AGU_SPACE_P, '0, '0, 1'b0, 32'hFF00_003F, '0, '0));
        for (int i = 0; i < 6; i++) begin
            pcm.issue(mk(AGU_OP_UPD, u[i], AGU_SPACE_X, '0, '0, 1'b0, '0, '0, '0));
            if (i > 0) chk(rsp.addr, a[i-1]);
        end
        pcm.idle();
        @(posedge clk_i);
        chk(rsp.addr, a[5]);
        go(mk(AGU_OP_WR_MOD, AGU_UPD_NONE, AGU_SPACE_P, '0, '0, 1'b0, 32'hFE00_003F, '0, '0));
        go(mk(AGU_OP_UPD, AGU_UPD_POST_DECN, AGU_SPACE_X, '0, '0, 1'b0, '0, '0, '0));
        chk(rsp.addr, 32'h0000_0140);
        go(mk(AGU_OP_UPD, AGU_UPD_NONE, AGU_SPACE_X, '0, '0, 1'b0, '0, '0, '0));
        chk(rsp.addr, 32'hFFFF_FECF);
    endtask : t_wrap
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        t_disp();
        t_branch();
        t_lra();
        t_wrap();
        stop_test();
    end
endmodule : tb_address_generation_unit
